// ### osc_pkg.sv
// Shared constants and types for the oscillator run control and stabilization status block
package osc_pkg;

    // ****************************************************************
    // Register addresses on the CPU memory bus
    // ****************************************************************
    localparam int          ADDR_W         = 20;
    localparam logic [19:0] ADDR_PIN_MODE  = 20'hfffa0;
    localparam logic [19:0] ADDR_STOP_CTL  = 20'hfffa1;
    localparam logic [19:0] ADDR_STAB_STAT = 20'hfffa2;
    localparam logic [19:0] ADDR_STAB_SEL  = 20'hfffa3;

    // ****************************************************************
    // Reset values and writable-bit masks
    // ****************************************************************
    localparam logic [7:0] PIN_MODE_RST  = 8'h00;
    localparam logic [7:0] STOP_CTL_RST  = 8'hc0;
    localparam logic [7:0] STAB_STAT_RST = 8'h00;
    localparam logic [2:0] STAB_SEL_RST  = 3'h7;
    localparam logic [7:0] PIN_MODE_MASK = 8'hd1;
    localparam logic [7:0] STOP_CTL_MASK = 8'hc1;
    localparam logic [7:0] RD_NONE       = 8'h00;
    localparam logic [4:0] STAB_SEL_PAD  = 5'h00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int PM_EXT_CLK_SEL = 7;
    localparam int PM_OSC_PIN_SEL = 6;
    localparam int PM_SUB_PIN_SEL = 4;
    localparam int PM_HIGH_GAIN   = 0;
    localparam int SC_HS_STOP     = 7;
    localparam int SC_SUB_STOP    = 6;
    localparam int SC_INT_STOP    = 0;
    localparam int STAB_SEL_MSB   = 2;

    // ****************************************************************
    // Stabilization counter
    // ****************************************************************
    localparam int STAB_BITS = 8;
    localparam int CNT_W     = 19;
    localparam logic [18:0] CNT_ZERO = 19'h00000;
    localparam logic [18:0] CNT_ONE  = 19'h00001;
    // Threshold per selection code; code k drives status bit 7-k
    localparam logic [18:0] STAB_THR [STAB_BITS] = '{
        19'h00100, 19'h00200, 19'h00400, 19'h00800,
        19'h02000, 19'h08000, 19'h20000, 19'h40000
    };

    // High-speed pin mode, one-hot
    typedef enum logic [2:0] {
        HS_PORT = 3'b001,
        HS_XTAL = 3'b010,
        HS_EXT  = 3'b100
    } osc_hs_mode_t;

    // Stabilization counter state, one-hot
    typedef enum logic [2:0] {
        CNT_IDLE = 3'b001,
        CNT_RUN  = 3'b010,
        CNT_DONE = 3'b100
    } osc_cnt_state_t;

endpackage

// ### osc_edge_sync.sv
// Two-flop synchronizer with rising-edge pulse for the X1 clock pin
`timescale 1ns/10ps
`default_nettype none
module osc_edge_sync (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      rise
);
    import osc_pkg::*;

    logic meta;
    logic sync;
    logic sync_d;

    // ****************************************************************
    // Synchronizer; meta is read only by sync
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta   <= 1'b0;
            sync   <= 1'b0;
            sync_d <= 1'b0;
        end else begin
            meta   <= async_in;
            sync   <= meta;
            sync_d <= sync;
        end
    end

    // X1 tops out well below half the system rate, so no edge is missed
    assign rise = sync & ~sync_d;

endmodule
`default_nettype wire

// ### osc_stab_counter.sv
// Oscillation stabilization counter with thermometer-coded status
`timescale 1ns/10ps
`default_nettype none
module osc_stab_counter #(
    parameter int unsigned THR_DIV_LOG2 = 0
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       clear,
    input  wire logic       run,
    input  wire logic       x1_edge,
    input  wire logic [2:0] sel,
    output logic [7:0]      status,
    output logic            done
);
    import osc_pkg::*;

    osc_cnt_state_t state;
    logic [18:0]    count;
    logic [18:0]    limit;

    // Selected stop point, shortened only in simulation
    assign limit = STAB_THR[sel] >> THR_DIV_LOG2;

    // ****************************************************************
    // Count X1 edges up to the selected time
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= CNT_IDLE;
            count <= CNT_ZERO;
        end else if (clear) begin
            state <= CNT_IDLE;
            count <= CNT_ZERO;
        end else begin
            unique case (state)
                CNT_IDLE: begin
                    if (run) begin
                        state <= CNT_RUN;
                    end
                end
                CNT_RUN: begin
                    if (count >= limit) begin
                        state <= CNT_DONE;
                    end else if (run && x1_edge) begin
                        count <= count + CNT_ONE;
                    end
                end
                CNT_DONE: begin
                    state <= CNT_DONE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Sticky status bits, bit 7 carries the shortest threshold
    // Rising thresholds make the bits fill as a thermometer
    // ****************************************************************
    for (genvar k = 0; k < STAB_BITS; k++) begin : g_stat
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                status[STAB_BITS-1-k] <= 1'b0;
            end else if (clear) begin
                status[STAB_BITS-1-k] <= 1'b0;
            end else if (count >= (STAB_THR[k] >> THR_DIV_LOG2)) begin
                status[STAB_BITS-1-k] <= 1'b1;
            end
        end
    end

    assign done = (state == CNT_DONE);

endmodule
`default_nettype wire

// ### osc_ctrl.sv
// Oscillator run control registers and stabilization status, top level
`timescale 1ns/10ps
`default_nettype none

module osc_ctrl #(
    parameter int unsigned THR_DIV_LOG2 = 0
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic [19:0]           bus_addr,
    input  wire logic                  bus_wr,
    input  wire logic                  bus_rd,
    input  wire logic                  bus_byte,
    input  wire logic [2:0]            bus_bit,
    input  wire logic [7:0]            bus_wdata,
    output logic [7:0]                 bus_rdata,
    input  wire logic                  stop_mode,
    input  wire logic                  x1_clk_in,
    output var osc_pkg::osc_hs_mode_t  hs_pin_mode,
    output logic                       x1_osc_run,
    output logic                       ext_clk_valid,
    output logic                       xt1_osc_run,
    output logic                       hio_run,
    output logic                       high_gain,
    output logic                       pin_mode_locked,
    output logic                       stab_done
);
    import osc_pkg::*;

    logic [7:0]   pin_mode;
    logic [7:0]   stop_ctl;
    logic [2:0]   stab_sel;
    logic [7:0]   stab_stat;
    logic         pin_mode_written;
    logic         x1_edge;
    logic         stab_clear;
    logic         stab_run;
    logic         wr_pin_mode;
    logic         wr_stop_ctl;
    logic         wr_stab_sel;
    logic [7:0]   next_stop_ctl;
    logic [7:0]   next_rdata;
    osc_hs_mode_t next_mode;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Bit writes only touch registers that allow them
    assign wr_pin_mode = bus_wr && (bus_addr == ADDR_PIN_MODE) && bus_byte;
    assign wr_stop_ctl = bus_wr && (bus_addr == ADDR_STOP_CTL);
    assign wr_stab_sel = bus_wr && (bus_addr == ADDR_STAB_SEL) && bus_byte;

    // Bit write merges one data bit into the old byte
    always_comb begin
        next_stop_ctl = stop_ctl;
        if (bus_byte) begin
            next_stop_ctl = bus_wdata;
        end else begin
            next_stop_ctl[bus_bit] = bus_wdata[0];
        end
        next_stop_ctl = next_stop_ctl & STOP_CTL_MASK;
    end

    // ****************************************************************
    // Pin mode register, write once
    // ****************************************************************
    // The lock guards pin modes against a runaway loop
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_mode         <= PIN_MODE_RST;
            pin_mode_written <= 1'b0;
        end else if (wr_pin_mode && !pin_mode_written) begin
            pin_mode         <= bus_wdata & PIN_MODE_MASK;
            pin_mode_written <= 1'b1;
        end
    end

    // ****************************************************************
    // Stop control register
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stop_ctl <= STOP_CTL_RST;
        end else if (wr_stop_ctl) begin
            stop_ctl <= next_stop_ctl;
        end
    end

    // ****************************************************************
    // Stabilization time select register
    // ****************************************************************
    // Changing it mid-count moves the stop point; software must wait
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stab_sel <= STAB_SEL_RST;
        end else if (wr_stab_sel) begin
            stab_sel <= bus_wdata[STAB_SEL_MSB:0];
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Bit reads get the whole byte; the CPU picks its bit
    always_comb begin
        next_rdata = RD_NONE;
        if (bus_rd) begin
            if (bus_addr == ADDR_PIN_MODE) begin
                next_rdata = pin_mode;
            end else if (bus_addr == ADDR_STOP_CTL) begin
                next_rdata = stop_ctl;
            end else if (bus_addr == ADDR_STAB_STAT) begin
                next_rdata = stab_stat;
            end else if (bus_addr == ADDR_STAB_SEL) begin
                next_rdata = {STAB_SEL_PAD, stab_sel};
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bus_rdata <= RD_NONE;
        end else begin
            bus_rdata <= next_rdata;
        end
    end

    // ****************************************************************
    // Oscillator control outputs
    // ****************************************************************
    // Select bit low forces port mode whatever the external bit says
    always_comb begin
        next_mode = HS_PORT;
        if (pin_mode[PM_OSC_PIN_SEL]) begin
            next_mode = pin_mode[PM_EXT_CLK_SEL] ? HS_EXT : HS_XTAL;
        end
    end

    // Registered so the analog controls never see decode glitches
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hs_pin_mode   <= HS_PORT;
            x1_osc_run    <= 1'b0;
            ext_clk_valid <= 1'b0;
            xt1_osc_run   <= 1'b0;
            hio_run       <= 1'b1;
            high_gain     <= 1'b0;
        end else begin
            hs_pin_mode   <= next_mode;
            x1_osc_run    <= (next_mode == HS_XTAL) && !stop_ctl[SC_HS_STOP] && !stop_mode;
            ext_clk_valid <= (next_mode == HS_EXT) && !stop_ctl[SC_HS_STOP] && !stop_mode;
            xt1_osc_run   <= pin_mode[PM_SUB_PIN_SEL] && !stop_ctl[SC_SUB_STOP];
            hio_run       <= !stop_ctl[SC_INT_STOP] && !stop_mode;
            high_gain     <= pin_mode[PM_HIGH_GAIN];
        end
    end

    assign pin_mode_locked = pin_mode_written;

    // ****************************************************************
    // Stabilization counter
    // ****************************************************************
    // Stop mode holds the count cleared; its release restarts counting
    assign stab_clear = stop_mode || stop_ctl[SC_HS_STOP];
    assign stab_run   = (next_mode == HS_XTAL) && !stop_ctl[SC_HS_STOP] && !stop_mode;

    osc_edge_sync u_x1_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (x1_clk_in),
        .rise     (x1_edge)
    );

    osc_stab_counter #(
        .THR_DIV_LOG2 (THR_DIV_LOG2)
    ) u_stab (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clear   (stab_clear),
        .run     (stab_run),
        .x1_edge (x1_edge),
        .sel     (stab_sel),
        .status  (stab_stat),
        .done    (stab_done)
    );

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ****************************************************************
    // Register assertions
    // ****************************************************************
    // Reset checks run with the default disable lifted
    pin_mode_once_a: assert property ($past(pin_mode_written) |-> $stable(pin_mode))
        else $error("pin mode register changed after first write");

    pin_reset_a: assert property (disable iff (1'b0) $fell(rst) |-> (pin_mode == PIN_MODE_RST) && !pin_mode_written)
        else $error("pin mode not at reset value");

    pin_lock_a: assert property (wr_pin_mode && !pin_mode_written |=> pin_mode_written && (pin_mode == ($past(bus_wdata) & PIN_MODE_MASK)))
        else $error("first pin mode write not taken");

    stop_reset_a: assert property (disable iff (1'b0) $fell(rst) |-> (stop_ctl == STOP_CTL_RST))
        else $error("stop control not at reset value");

    stop_write_a: assert property (wr_stop_ctl && bus_byte |=> (stop_ctl == ($past(bus_wdata) & STOP_CTL_MASK)))
        else $error("stop control byte write not taken");

    stop_resv_a: assert property (stop_ctl[5:1] == 5'h00)
        else $error("stop control reserved bits not zero");

    sel_reset_a: assert property (disable iff (1'b0) $fell(rst) |-> (stab_sel == STAB_SEL_RST))
        else $error("time select not at reset value");

    rdata_idle_a: assert property (!bus_rd |=> (bus_rdata == RD_NONE))
        else $error("read data not idle without read");

    stat_read_a: assert property (bus_rd && (bus_addr == ADDR_STAB_STAT) |=> (bus_rdata == $past(stab_stat)))
        else $error("status readback wrong");

    // ****************************************************************
    // Oscillator control assertions
    // ****************************************************************
    hs_stop_a: assert property (stop_ctl[SC_HS_STOP] |=> !x1_osc_run && !ext_clk_valid)
        else $error("high-speed source active while stopped");

    hs_run_a: assert property (pin_mode[PM_OSC_PIN_SEL] && !pin_mode[PM_EXT_CLK_SEL] && !stop_ctl[SC_HS_STOP] && !stop_mode |=> x1_osc_run)
        else $error("crystal not running when enabled");

    port_mode_a: assert property (!pin_mode[PM_OSC_PIN_SEL] |=> (hs_pin_mode == HS_PORT) && !x1_osc_run)
        else $error("port mode not applied");

    ext_mode_a: assert property ((hs_pin_mode == HS_EXT) |-> !x1_osc_run)
        else $error("crystal runs in external clock mode");

    xt1_port_a: assert property (!pin_mode[PM_SUB_PIN_SEL] || stop_ctl[SC_SUB_STOP] |=> !xt1_osc_run)
        else $error("subsystem oscillator runs when it should not");

    sub_run_a: assert property (pin_mode[PM_SUB_PIN_SEL] && !stop_ctl[SC_SUB_STOP] |=> xt1_osc_run)
        else $error("subsystem oscillator not running when enabled");

    hio_stop_a: assert property (stop_ctl[SC_INT_STOP] |=> !hio_run)
        else $error("internal oscillator runs while stopped");

    hio_run_a: assert property (!stop_ctl[SC_INT_STOP] && !stop_mode |=> hio_run)
        else $error("internal oscillator stopped while enabled");

    gain_follow_a: assert property (1'b1 |=> (high_gain == $past(pin_mode[PM_HIGH_GAIN])))
        else $error("gain select does not follow pin mode");

    // ****************************************************************
    // Stabilization assertions
    // ****************************************************************
    stat_reset_a: assert property (disable iff (1'b0) $fell(rst) |-> (stab_stat == STAB_STAT_RST))
        else $error("status not cleared by reset");

    stat_clear_a: assert property (stab_clear |=> (stab_stat == STAB_STAT_RST))
        else $error("status not cleared");

    done_clear_a: assert property (stab_clear |=> !stab_done)
        else $error("counter done survives clear");

    stat_thermo_a: assert property (stab_stat == ~(8'hff >> $countones(stab_stat)))
        else $error("status not a thermometer code");

    stat_sticky_a: assert property (!stab_clear |=> ((stab_stat & $past(stab_stat)) == $past(stab_stat)))
        else $error("status bit dropped without clear");

    stab_halt_a: assert property (stab_done && !stab_clear |=> $stable(stab_stat))
        else $error("status moved after counter halted");

    // ****************************************************************
    // Covers
    // ****************************************************************
    pin_lock_c: cover property (pin_mode_written ##1 (wr_pin_mode && (bus_wdata != pin_mode)));

    stat_full_c: cover property (stab_stat == 8'hff);

    stop_release_c: cover property ($fell(stop_mode) ##[1:50] (stab_stat != STAB_STAT_RST));

    ext_mode_c: cover property (ext_clk_valid);

    stab_run_c: cover property (stab_run && x1_edge);

endmodule
`default_nettype wire

// ### osc_xtal_model.sv
// Behavioural model of the high-speed crystal oscillator that feeds the X1 pin
`timescale 1ns/10ps
`default_nettype none
module osc_xtal_model #(
    parameter int HALF_NS  = 37,
    parameter int START_NS = 500
) (
    input  wire logic run,
    output logic      x1
);
    // ****************************************************************
    // Oscillation
    // ****************************************************************
    initial begin
        x1 = 1'b0;
    end

    // The pin stands still while stopped; a real crystal needs a start-up
    // interval before its first swing, so no edge appears during it
    always begin
        wait (run === 1'b1);
        #(START_NS);
        while (run === 1'b1) begin
            #(HALF_NS) x1 = ~x1;
        end
        x1 = 1'b0;
    end
endmodule
`default_nettype wire

// ### osc_ctrl_tb_top.sv
// Self-checking testbench for the oscillator run control and stabilization status block
`timescale 1ns/10ps
`default_nettype none
module osc_ctrl_tb_top;
    import osc_pkg::*;
    localparam int CEIL = 50000;
    logic         clk_sys;
    logic         rst;
    logic [19:0]  bus_addr;
    logic         bus_wr;
    logic         bus_rd;
    logic         bus_byte;
    logic [2:0]   bus_bit;
    logic [7:0]   bus_wdata;
    logic [7:0]   bus_rdata;
    logic         stop_mode;
    wire logic    x1_clk;
    osc_hs_mode_t hs_pin_mode;
    logic         x1_osc_run;
    logic         ext_clk_valid;
    logic         xt1_osc_run;
    logic         hio_run;
    logic         high_gain;
    logic         pin_mode_locked;
    logic         stab_done;
    int           err_total;
    int           tests_run;
    int           cycles;

    // Short thresholds: 1,2,4,8,32,128,512,1024 X1 edges
    osc_ctrl #(.THR_DIV_LOG2(8)) i_osc_ctrl (
        .clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_byte(bus_byte), .bus_bit(bus_bit), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .stop_mode(stop_mode), .x1_clk_in(x1_clk), .hs_pin_mode(hs_pin_mode),
        .x1_osc_run(x1_osc_run), .ext_clk_valid(ext_clk_valid), .xt1_osc_run(xt1_osc_run),
        .hio_run(hio_run), .high_gain(high_gain), .pin_mode_locked(pin_mode_locked), .stab_done(stab_done)
    );

    // Crystal near 13.5 MHz, so software must pick the high gain range
    osc_xtal_model i_osc_xtal_model (
        .run(x1_osc_run),
        .x1 (x1_clk)
    );

    // ****************************************************************
    // Clock, timeout and shared tasks
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // A hang counts as a mismatch and ends the run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == CEIL) begin
            err_total++;
            results;
        end
    end

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Strobe raised after a falling edge, dropped one cycle later
    task automatic wr(input logic [19:0] a, input logic byt, input logic [2:0] b, input logic [7:0] d);
        @(negedge clk_sys);
        bus_addr = a;
        bus_byte = byt;
        bus_bit = b;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge clk_sys);
        bus_wr = 1'b0;
    endtask

    // Read data is registered at the taking edge, so it is sampled half a cycle later
    task automatic rd(input logic [19:0] a, output logic [7:0] v);
        @(negedge clk_sys);
        bus_addr = a;
        bus_byte = 1'b1;
        bus_rd = 1'b1;
        @(negedge clk_sys);
        bus_rd = 1'b0;
        v = bus_rdata;
    endtask

    task automatic settle;
        repeat (2) @(negedge clk_sys);
    endtask

    task automatic do_reset;
        @(negedge clk_sys);
        rst = 1'b1;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
    endtask

    // Legal status codes fill from bit 7 down with no gaps
    function automatic logic therm(input logic [7:0] v);
        return ((~v) & ((~v) + 8'h01)) == 8'h00;
    endfunction

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        logic [7:0] v;
        rd(ADDR_STOP_CTL, v);
        check("stop_ctl_reset", v, 8'hc0);
        rd(ADDR_STAB_STAT, v);
        check("stab_stat_reset", v, 8'h00);
        rd(ADDR_STAB_SEL, v);
        check("stab_sel_reset", v, 8'h07);
        rd(20'hfffa4, v);
        check("unmapped_read", v, 8'h00);
        check("hio_after_reset", {7'h00, hio_run}, 8'h01);
        check("mode_after_reset", {5'h00, hs_pin_mode}, {5'h00, HS_PORT});
    endtask

    // Stop control masking and bit writes while both pins are still ports
    task automatic t_stop_ctl;
        logic [7:0] v;
        wr(ADDR_STOP_CTL, 1'b1, 3'h0, 8'hff);
        rd(ADDR_STOP_CTL, v);
        check("stop_ctl_mask", v, 8'hc1);
        settle;
        check("hio_stopped", {7'h00, hio_run}, 8'h00);
        wr(ADDR_STOP_CTL, 1'b0, 3'h0, 8'h00);
        wr(ADDR_STOP_CTL, 1'b0, 3'h7, 8'h00);
        wr(ADDR_STOP_CTL, 1'b0, 3'h6, 8'h00);
        rd(ADDR_STOP_CTL, v);
        check("stop_ctl_bit_writes", v, 8'h00);
        settle;
        check("hio_running", {7'h00, hio_run}, 8'h01);
        check("x1_in_port_mode", {7'h00, x1_osc_run}, 8'h00);
        check("xt1_in_port_mode", {7'h00, xt1_osc_run}, 8'h00);
        wr(ADDR_STAB_STAT, 1'b1, 3'h0, 8'hff);
        rd(ADDR_STAB_STAT, v);
        check("stab_stat_write_ignored", v, 8'h00);
    endtask

    // Four pin mode codes, each after a fresh reset; the last leaves crystal mode
    task automatic t_modes;
        logic [7:0]   code [4] = '{8'h00, 8'h80, 8'hd0, 8'h41};
        osc_hs_mode_t mode [4] = '{HS_PORT, HS_PORT, HS_EXT, HS_XTAL};
        logic [7:0]   v;
        for (int i = 0; i < 4; i++) begin
            do_reset;
            wr(ADDR_PIN_MODE, 1'b0, 3'h6, 8'h01);
            settle;
            check("pin_bit_write_no_lock", {7'h00, pin_mode_locked}, 8'h00);
            wr(ADDR_PIN_MODE, 1'b1, 3'h0, code[i]);
            wr(ADDR_PIN_MODE, 1'b1, 3'h0, 8'h11);
            rd(ADDR_PIN_MODE, v);
            check("pin_first_write_only", v, code[i]);
            check("pin_lock_set", {7'h00, pin_mode_locked}, 8'h01);
            wr(ADDR_STOP_CTL, 1'b1, 3'h0, 8'h00);
            settle;
            check("pin_mode", {5'h00, hs_pin_mode}, {5'h00, mode[i]});
            check("gain", {7'h00, high_gain}, {7'h00, code[i][0]});
            check("ext_valid", {7'h00, ext_clk_valid}, {7'h00, code[i] == 8'hd0});
            check("x1_run", {7'h00, x1_osc_run}, {7'h00, code[i] == 8'h41});
            check("xt1_run", {7'h00, xt1_osc_run}, {7'h00, code[i][4]});
        end
    endtask

    // Start counting, poll the status while it fills, then check the stop point
    task automatic t_stab(input logic from_stop, input logic [2:0] sel, input logic [7:0] exp);
        logic [7:0] v;
        logic [7:0] prev;
        wr(ADDR_STAB_SEL, 1'b1, 3'h0, {5'h00, sel});
        if (from_stop) begin
            @(negedge clk_sys);
            stop_mode = 1'b0;
        end else begin
            wr(ADDR_STOP_CTL, 1'b0, 3'h7, 8'h00);
        end
        rd(ADDR_STAB_STAT, v);
        check("stat_during_startup", v, 8'h00);
        prev = 8'h00;
        for (int n = 0; n < 6000 && stab_done !== 1'b1; n++) begin
            rd(ADDR_STAB_STAT, v);
            check("stat_thermometer", {7'h00, therm(v)}, 8'h01);
            check("stat_sticky", prev & ~v, 8'h00);
            prev = v;
        end
        repeat (200) @(negedge clk_sys);
        rd(ADDR_STAB_STAT, v);
        check("stat_stop_point", v, exp);
    endtask

    task automatic t_crystal;
        logic [7:0] v;
        wr(ADDR_STOP_CTL, 1'b0, 3'h7, 8'h01);
        settle;
        check("x1_stopped", {7'h00, x1_osc_run}, 8'h00);
        t_stab(1'b0, 3'h3, 8'hf0);
        @(negedge clk_sys);
        stop_mode = 1'b1;
        settle;
        rd(ADDR_STAB_STAT, v);
        check("stat_cleared_by_stop", v, 8'h00);
        t_stab(1'b1, 3'h7, 8'hff);
        wr(ADDR_STOP_CTL, 1'b0, 3'h7, 8'h01);
        settle;
        rd(ADDR_STAB_STAT, v);
        check("stat_cleared_by_hs_stop", v, 8'h00);
        check("done_cleared", {7'h00, stab_done}, 8'h00);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rst = 1'b1;
        bus_addr = 20'h00000;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_byte = 1'b1;
        bus_bit = 3'h0;
        bus_wdata = 8'h00;
        stop_mode = 1'b0;
        err_total = 0;
        tests_run = 0;
        cycles = 0;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        t_reset;
        t_stop_ctl;
        t_modes;
        t_crystal;
        results;
    end
endmodule
`default_nettype wire
